//--- shared/media_cmd_cfg.svh
/*
 Register indices, field positions and reset values of the media command port.
 Assumes byte-wide registers; each index is placed at byte address index * 4.
*/
`ifndef MEDIA_CMD_CFG_SVH
`define MEDIA_CMD_CFG_SVH

`define IDX_COMMAND 14'h1020
`define IDX_OPTIONS 14'h1021
`define IDX_ADDR_LO 14'h1024
`define IDX_ADDR_HI 14'h1029
`define IDX_LEN_LO 14'h102c
`define IDX_LEN_HI 14'h102f
`define IDX_STATUS 14'h1030

`define CMD_PEND_BIT 7
`define CMD_TGT_HI 5
`define CMD_TGT_LO 3
`define CMD_OP_HI 2
`define CMD_OP_LO 0

`define OPT_BLK_HI 6
`define OPT_BLK_LO 4
`define OPT_UNIT_BIT 3
`define OPT_TYPE_HI 2
`define OPT_TYPE_LO 0

`define ADDR_BIT0_POS 7

`define CMD_RESET 8'h00
`define OPT_RESET 8'h00
`define ADDR_RESET 41'h000_0000_0000
`define LEN_RESET 32'h0000_0000

`define ST_AUTO 0
`define ST_READY_ONE 1
`define ST_READY_TWO 2
`define ST_BUSY 3
`define ST_WR_IN_AUTO 4
`define ST_BAD_TGT 5

`endif

//--- shared/media_cmd_pkg.sv
/*
 Types of the media command port: field codes, the command bundle and issue states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package media_cmd_pkg;

   typedef enum logic [2:0] {
      TGT_CARD_ONE = 3'b011,
      TGT_CARD_TWO = 3'b100
   } target_e;

   typedef enum logic [2:0] {
      OP_NEW_READ = 3'b000,
      OP_CONT_READ = 3'b001,
      OP_NEW_WRITE = 3'b010,
      OP_CONT_WRITE = 3'b011,
      OP_MANUAL_READ = 3'b100,
      OP_MANUAL_WRITE = 3'b101
   } op_e;

   typedef enum logic [2:0] {
      BLK_256 = 3'b000,
      BLK_512 = 3'b001,
      BLK_1024 = 3'b010,
      BLK_2048 = 3'b011,
      BLK_4096 = 3'b100
   } blk_e;

   typedef enum logic {
      ISS_IDLE = 1'b0,
      ISS_WAIT = 1'b1
   } issue_state_e;

   typedef struct packed {
      logic [2:0] dev_select;
      logic [2:0] command;
      logic [2:0] block_size;
      logic unit_index_bit;
      logic [2:0] dev_options;
      logic [31:0] byte_count_field;
      logic [40:0] start_addr;
   } cmd_fields_s;

endpackage

//--- rtl/cmd_port_issue.sv
/*
 Offers a pending command to the selected card controller and reports acceptance.
 Assumes acknowledges come from logic on mclk; a reserved target is accepted at once.
*/
module cmd_port_issue (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic pending,
   input wire logic [2:0] target,
   input wire logic ack_one,
   input wire logic ack_two,
   output logic valid_one,
   output logic valid_two,
   output logic accepted,
   output logic bad_target
);
   import media_cmd_pkg::*;

   issue_state_e state_r;
   issue_state_e state_nxt;
   logic pick_one;
   logic pick_two;
   logic acked;

   assign pick_one = (target == TGT_CARD_ONE);
   assign pick_two = (target == TGT_CARD_TWO);
   assign acked = (valid_one & ack_one) | (valid_two & ack_two);
   // R5 reserved codes
   assign bad_target = (state_r == ISS_IDLE) & pending & ~pick_one & ~pick_two;
   // R21 ack is acceptance
   assign accepted = ((state_r == ISS_WAIT) & acked) | bad_target;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ISS_IDLE: begin
            if (pending && (pick_one || pick_two)) begin
               state_nxt = ISS_WAIT;
            end
         end
         ISS_WAIT: begin
            if (acked) begin
               state_nxt = ISS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ISS_IDLE;
         valid_one <= 1'b0;
         valid_two <= 1'b0;
      end else begin
         state_r <= state_nxt;
         // R21 strobe to selected
         valid_one <= (state_nxt == ISS_WAIT) & ((state_r == ISS_WAIT) ? valid_one : pick_one);
         valid_two <= (state_nxt == ISS_WAIT) & ((state_r == ISS_WAIT) ? valid_two : pick_two);
      end
   end

endmodule // cmd_port_issue

//--- rtl/media_command_port_regs.sv
/*
 Register bank of the media command port, an APB slave, plus the command hand-off
 to two card controllers and the load path from the automatic sequencer.
 Assumes APB master, sequencer and controllers all run on mclk.
*/
// Summary of operation
// R1: Processor and sequencer both load the port; manual writes drive it when sequencer is off.
// R2: Software leaves the port alone while the sequencer runs.
// R3: Processor sets pending bit 7; hardware clears it once the command is accepted.
// R4: In automatic mode the sequencer, not the processor, drives the pending flag.
// R5: Target field 5:3 picks controller: 011 card one, 100 card two, others reserved.
// R6: Sequencer overwrites target field from the active unit's descriptor.
// R7: Command field 2:0: new/continue read and write, manual read and write.
// R8: Sequencer overwrites the command field from the current storage command.
// R9: Software loads options, length and address before writing the command register.
// R10: Block size field 6:4 codes 256 up to 4096 bytes; others reserved.
// R11: Sequencer overwrites the block size from the second unit descriptor.
// R12: Options bit 3 picks the unit; sequencer overwrites it from the descriptor.
// R13: Options 2:0 give device type and control path; sequencer overwrites them.
// R14: Transfer length is a 32-bit byte count.
// R15: Sequencer overwrites the transfer length from the command wrapper.
// R16: Start address is a 41-bit byte address.
// R17: Address bytes 1024..1027 hold bits 16:9 up to 40:33, 1029 bits 8:1, 1028 bit 0.
// R18: Sequencer overwrites the start address with the block address.
// R19: Selected controller reports ready or busy back over the port.
// R20: Reserved command and option bits read zero and ignore writes.
// R21: Pending command is strobed to the selected controller; its acknowledge means accepted.
`include "media_cmd_cfg.svh"

module media_command_port_regs #(
   parameter int ADDR_W = 16
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic seq_active,
   input wire logic seq_load,
   input wire media_cmd_pkg::cmd_fields_s seq_fields,
   output media_cmd_pkg::cmd_fields_s port_fields,
   output logic valid_one,
   output logic valid_two,
   input wire logic ack_one,
   input wire logic ack_two,
   input wire logic ready_one,
   input wire logic ready_two,
   output logic media_ready
);
   import media_cmd_pkg::*;

   // Stored fields
   logic pend_r;
   logic [2:0] tgt_r;
   logic [2:0] op_r;
   logic [2:0] blk_r;
   logic unit_r;
   logic [2:0] type_r;
   logic [40:0] addr_r;
   logic [31:0] len_r;
   logic wr_in_auto_r;
   logic bad_tgt_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic media_ready_r;

   // Next values
   logic pend_nxt;
   logic [2:0] tgt_nxt;
   logic [2:0] op_nxt;
   logic [2:0] blk_nxt;
   logic unit_nxt;
   logic [2:0] type_nxt;
   logic [40:0] addr_nxt;
   logic [31:0] len_nxt;
   logic [47:0] addr_view;
   logic [47:0] view_nxt;

   // Bus decode
   logic [13:0] idx;
   logic aligned;
   logic hit_cmd;
   logic hit_opt;
   logic hit_addr;
   logic hit_len;
   logic hit_stat;
   logic mapped;
   logic acc;
   logic commit;
   logic wr_commit;
   logic man_wr;
   logic wr_cmd;
   logic wr_opt;
   logic wr_stat;
   logic [2:0] addr_k;
   logic [1:0] len_k;
   logic [5:0] wr_addr_b;
   logic [3:0] wr_len_b;
   logic seq_ld;

   // Read path
   logic [7:0] cmd_byte;
   logic [7:0] opt_byte;
   logic [7:0] stat_byte;
   logic [7:0] addr_byte;
   logic [7:0] len_byte;
   logic [7:0] rd_byte;

   // Issue path
   logic accepted;
   logic bad_target;
   logic pend_set;
   logic pend_clr_sw;
   logic acc_open;
   logic rd_open;
   logic stat_clr_auto;
   logic stat_clr_tgt;
   logic sel_ready;
   logic addr_in_view;

   // Reset images of the two byte registers
   localparam logic [7:0] CMD_RST = `CMD_RESET;
   localparam logic [7:0] OPT_RST = `OPT_RESET;

   // Byte registers sit one per word; paddr[1:0] must be zero
   assign idx = paddr[15:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign hit_cmd = aligned & (idx == `IDX_COMMAND);
   assign hit_opt = aligned & (idx == `IDX_OPTIONS);
   assign hit_addr = aligned & (idx >= `IDX_ADDR_LO) & (idx <= `IDX_ADDR_HI);
   assign hit_len = aligned & (idx >= `IDX_LEN_LO) & (idx <= `IDX_LEN_HI);
   assign hit_stat = aligned & (idx == `IDX_STATUS);
   assign mapped = hit_cmd | hit_opt | hit_addr | hit_len | hit_stat;
   assign addr_k = 3'(idx - `IDX_ADDR_LO);
   assign len_k = 2'(idx - `IDX_LEN_LO);

   // Access phase: pready one cycle after it opens; writes land when pready is seen
   assign acc = psel & penable;
   assign acc_open = acc & ~pready_r;
   assign rd_open = acc_open & ~pwrite;
   assign commit = acc & pready_r;
   assign wr_commit = commit & pwrite & mapped;

   // R2 writes refused in auto, except status register writes
   assign man_wr = wr_commit & ~seq_active;
   // R1 processor path
   assign wr_cmd = man_wr & hit_cmd;
   assign wr_opt = man_wr & hit_opt;
   assign wr_stat = wr_commit & hit_stat;
   // R6 sequencer load
   assign seq_ld = seq_active & seq_load;

   // R4 pending source
   assign pend_set = seq_active ? seq_ld : (wr_cmd & pwdata[`CMD_PEND_BIT]);
   // A zero written to the pending bit clears it; an offer already strobed stays until acknowledged
   assign pend_clr_sw = wr_cmd & ~pwdata[`CMD_PEND_BIT];
   // R3 set wins over clear
   assign pend_nxt = pend_set | (pend_r & ~accepted & ~pend_clr_sw);

   // R5 target field
   assign tgt_nxt = seq_ld ? seq_fields.dev_select :
                    wr_cmd ? pwdata[`CMD_TGT_HI:`CMD_TGT_LO] : tgt_r;
   // R7 R8 command field
   assign op_nxt = seq_ld ? seq_fields.command :
                   wr_cmd ? pwdata[`CMD_OP_HI:`CMD_OP_LO] : op_r;
   // R10 R11 block size
   assign blk_nxt = seq_ld ? seq_fields.block_size :
                    wr_opt ? pwdata[`OPT_BLK_HI:`OPT_BLK_LO] : blk_r;
   // R12 unit bit
   assign unit_nxt = seq_ld ? seq_fields.unit_index_bit :
                     wr_opt ? pwdata[`OPT_UNIT_BIT] : unit_r;
   // R13 device type
   assign type_nxt = seq_ld ? seq_fields.dev_options :
                     wr_opt ? pwdata[`OPT_TYPE_HI:`OPT_TYPE_LO] : type_r;

   // R17 byte view of address
   assign addr_view = {addr_r[8:1], addr_r[0], 7'h00, addr_r[40:9]};

   // Address bytes follow the register map order
   genvar k;
   generate
      for (k = 0; k < 6; k = k + 1) begin : g_addr
         assign wr_addr_b[k] = man_wr & hit_addr & (addr_k == 3'(k));
         assign view_nxt[8*k +: 8] = wr_addr_b[k] ? pwdata[7:0] : addr_view[8*k +: 8];
      end
      for (k = 0; k < 4; k = k + 1) begin : g_len
         assign wr_len_b[k] = man_wr & hit_len & (len_k == 2'(k));
         // R14 R15 length bytes
         assign len_nxt[8*k +: 8] = seq_ld ? seq_fields.byte_count_field[8*k +: 8] :
                                    wr_len_b[k] ? pwdata[7:0] : len_r[8*k +: 8];
      end
   endgenerate

   // R16 R18 address load
   assign addr_nxt = seq_ld ? seq_fields.start_addr :
                     {view_nxt[31:0], view_nxt[47:40], view_nxt[32 + `ADDR_BIT0_POS]};

   // R20 reserved bits zero
   assign cmd_byte = {pend_r, 1'b0, tgt_r, op_r};
   assign opt_byte = {1'b0, blk_r, unit_r, type_r};
   // R19 ready and busy
   assign stat_byte = {2'b00, bad_tgt_r, wr_in_auto_r, pend_r, ready_two, ready_one, seq_active};
   // Only six address bytes exist; the guard keeps the select inside the view
   assign addr_in_view = (addr_k <= 3'h5);
   assign addr_byte = addr_in_view ? addr_view[{addr_k, 3'b000} +: 8] : 8'h00;
   assign len_byte = len_r[{len_k, 3'b000} +: 8];
   // Unmapped reads return zero; pslverr flags them
   assign rd_byte = hit_cmd ? cmd_byte :
                    hit_opt ? opt_byte :
                    hit_addr ? addr_byte :
                    hit_len ? len_byte :
                    hit_stat ? stat_byte : 8'h00;

   cmd_port_issue u_issue (
      .mclk(mclk),
      .resetn(resetn),
      .pending(pend_r),
      .target(tgt_r),
      .ack_one(ack_one),
      .ack_two(ack_two),
      .valid_one(valid_one),
      .valid_two(valid_two),
      .accepted(accepted),
      .bad_target(bad_target)
   );

   // R21 fields presented
   // Fields are not frozen while offered; software must not change them then
   assign port_fields = '{
      dev_select: tgt_r,
      command: op_r,
      block_size: blk_r,
      unit_index_bit: unit_r,
      dev_options: type_r,
      byte_count_field: len_r,
      start_addr: addr_r
   };

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign media_ready = media_ready_r;

   // Command byte
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pend_r <= CMD_RST[`CMD_PEND_BIT];
         tgt_r <= CMD_RST[`CMD_TGT_HI:`CMD_TGT_LO];
         op_r <= CMD_RST[`CMD_OP_HI:`CMD_OP_LO];
      end else begin
         pend_r <= pend_nxt;
         tgt_r <= tgt_nxt;
         op_r <= op_nxt;
      end
   end

   // Options byte
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         blk_r <= OPT_RST[`OPT_BLK_HI:`OPT_BLK_LO];
         unit_r <= OPT_RST[`OPT_UNIT_BIT];
         type_r <= OPT_RST[`OPT_TYPE_HI:`OPT_TYPE_LO];
      end else begin
         blk_r <= blk_nxt;
         unit_r <= unit_nxt;
         type_r <= type_nxt;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         addr_r <= `ADDR_RESET;
      end else begin
         addr_r <= addr_nxt;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         len_r <= `LEN_RESET;
      end else begin
         len_r <= len_nxt;
      end
   end

   assign stat_clr_auto = wr_stat & pwdata[`ST_WR_IN_AUTO];
   assign stat_clr_tgt = wr_stat & pwdata[`ST_BAD_TGT];

   // Sticky flags: hardware set wins over write-one-to-clear
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wr_in_auto_r <= 1'b0;
      end else begin
         wr_in_auto_r <= (wr_commit & seq_active & ~hit_stat) | (wr_in_auto_r & ~stat_clr_auto);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bad_tgt_r <= 1'b0;
      end else begin
         bad_tgt_r <= bad_target | (bad_tgt_r & ~stat_clr_tgt);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= acc_open;
         pslverr_r <= acc_open & ~mapped;
      end
   end

   // Read data stands only in the cycle that pready does
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prdata_r <= 32'h0000_0000;
      end else begin
         prdata_r <= rd_open ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // A reserved target reports busy
   assign sel_ready = (tgt_r == TGT_CARD_ONE) ? ready_one :
                      (tgt_r == TGT_CARD_TWO) ? ready_two : 1'b0;

   // R19 selected controller ready
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         media_ready_r <= 1'b0;
      end else begin
         media_ready_r <= sel_ready;
      end
   end

endmodule // media_command_port_regs

//--- bench/port_regs_checker_assertions.sv
/*
 Pin-level assertions and covers for the media command port register bank.
 Assumes one mclk domain; bound onto the design below.
*/
module port_regs_checker (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic seq_active,
   input wire logic seq_load,
   input wire media_cmd_pkg::cmd_fields_s seq_fields,
   input wire media_cmd_pkg::cmd_fields_s port_fields,
   input wire logic valid_one,
   input wire logic valid_two,
   input wire logic ack_one,
   input wire logic ack_two,
   input wire logic ready_one,
   input wire logic ready_two,
   input wire logic media_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   import media_cmd_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   wire logic sel_rdy = port_fields.dev_select == 3'h3 ? ready_one : port_fields.dev_select == 3'h4 && ready_two;
   wire logic wr_done = psel && penable && pready && pwrite;

   property p_hold;
      (valid_one && !ack_one) || (valid_two && !ack_two) |=> valid_one || valid_two;
   endproperty
   a_hold: assert property (p_hold) else $error("offer dropped early");
   property p_drop;
      (valid_one && ack_one) || (valid_two && ack_two) |=> !valid_one && !valid_two;
   endproperty
   a_drop: assert property (p_drop) else $error("offer kept after ack");
   property p_one;
      valid_one |-> port_fields.dev_select == 3'h3 && !valid_two;
   endproperty
   a_one: assert property (p_one) else $error("wrong controller strobed");
   property p_two;
      valid_two |-> port_fields.dev_select == 3'h4 && !valid_one;
   endproperty
   a_two: assert property (p_two) else $error("wrong second controller strobed");
   property p_load;
      seq_active && seq_load |=> port_fields == $past(seq_fields);
   endproperty
   a_load: assert property (p_load) else $error("sequencer load lost");
   property p_keep;
      seq_active && wr_done && !seq_load |=> $stable(port_fields);
   endproperty
   a_keep: assert property (p_keep) else $error("write took effect in auto mode");
   property p_ws;
      $rose(penable) |-> !pready ##1 pready;
   endproperty
   a_ws: assert property (p_ws) else $error("access timing wrong");
   property p_rdy;
      1'b1 |=> media_ready == $past(sel_rdy);
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready not forwarded");
   property p_zero;
      pready && !pwrite |-> prdata[31:8] == 24'h00_0000;
   endproperty
   a_zero: assert property (p_zero) else $error("upper read bits set");

   c_one: cover property (valid_one && ack_one);
   c_two: cover property (valid_two && ack_two);
   c_load: cover property (seq_active && seq_load);
   c_auto_wr: cover property (seq_active && wr_done);
endmodule // port_regs_checker

bind media_command_port_regs port_regs_checker port_regs_checker_inst (.mclk, .resetn, .psel, .penable, .pwrite,
   .prdata, .pready, .seq_active, .seq_load, .seq_fields, .port_fields, .valid_one, .valid_two, .ack_one,
   .ack_two, .ready_one, .ready_two, .media_ready);

//--- bench/card_ctrl_model.sv
/*
 Model of both card controllers: acknowledges an offer promptly or slowly.
 Assumes offers come from the port on mclk.
*/
module card_ctrl_model (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic slow,
   input wire logic valid_one,
   input wire logic valid_two,
   output logic ack_one,
   output logic ack_two,
   output logic ready_one,
   output logic ready_two
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] wait_r;
   wire logic due = wait_r == (slow ? 3'h5 : 3'h0);
   assign ack_one = valid_one && due;
   assign ack_two = valid_two && due;
   assign ready_one = !valid_one;
   assign ready_two = !valid_two;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         wait_r <= 3'h0;
      else if ((valid_one || valid_two) && !due)
         wait_r <= wait_r + 3'h1;
      else
         wait_r <= 3'h0;
   end
endmodule // card_ctrl_model

//--- bench/media_command_port_regs_tb_top.sv
/*
 Self-checking bench of the media command port register bank.
 Assumes package, header, design, model and checker are compiled first.
*/
module media_command_port_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import media_cmd_pkg::*;
   logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic slow = 1'b0, seq_active = 1'b0, seq_load = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   cmd_fields_s seq_fields = '0;
   cmd_fields_s port_fields;
   logic [31:0] prdata, rd;
   logic pready, pslverr, rerr, valid_one, valid_two, ack_one, ack_two, ready_one, ready_two, media_ready;
   int err_total = 0;
   int checks = 0;

   initial begin
      forever #2.5 mclk = ~mclk;
   end

   media_command_port_regs media_command_port_regs_inst (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .seq_active, .seq_load, .seq_fields, .port_fields, .valid_one, .valid_two,
      .ack_one, .ack_two, .ready_one, .ready_two, .media_ready);
   card_ctrl_model card_ctrl_model_inst (.mclk, .resetn, .slow, .valid_one, .valid_two, .ack_one, .ack_two,
      .ready_one, .ready_two);

   task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic give_up(input string what);
      err_total++;
      $display("[FAIL] %0t timeout %s", $time, what);
      finish_test();
   endtask

   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
         give_up("bus");
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_offer(input logic want);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while ((valid_one || valid_two) !== want && n < 20);
      if ((valid_one || valid_two) !== want)
         give_up("offer");
   endtask

   task automatic t_fields();
      logic [15:0] a[11] = '{16'h4090, 16'h4094, 16'h4098, 16'h409c, 16'h40a4, 16'h40a0, 16'h40b0, 16'h40b4,
         16'h40b8, 16'h40bc, 16'h4084};
      logic [7:0] d[11] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'hff, 8'h78, 8'h56, 8'h34, 8'h12, 8'hbd};
      apb(1'b0, 16'h4080, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "reset read");
      chk(port_fields, 86'h0, "reset fields");
      chk(media_ready, 1'b0, "reset ready");
      foreach (a[i])
         apb(1'b1, a[i], {24'h00_0000, d[i]});
      @(posedge mclk);
      chk(port_fields.start_addr, {32'h4433_2211, 8'h55, 1'h1}, "address");
      chk(port_fields.byte_count_field, 32'h1234_5678, "length");
      chk({port_fields.block_size, port_fields.unit_index_bit, port_fields.dev_options}, 7'h3d, "opts");
      apb(1'b0, 16'h40a0, 32'h0000_0000);
      chk(rd, 32'h0000_0080, "addr bit 0");
      apb(1'b0, 16'h4084, 32'h0000_0000);
      chk(rd, 32'h0000_003d, "opts read");
      $display("field test done");
   endtask

   task automatic t_issue();
      logic [2:0] tgt;
      for (int op = 0; op < 6; op++) begin
         tgt = op[0] ? 3'h4 : 3'h3;
         slow <= op[1];
         apb(1'b1, 16'h4080, {24'h00_0000, 2'h2, tgt, op[2:0]});
         wait_offer(1'b1);
         chk({valid_one, valid_two, port_fields.dev_select}, {op[0] ? 2'h1 : 2'h2, tgt}, "strobe");
         chk(port_fields.command, op[2:0], "op");
         @(posedge mclk);
         chk(media_ready, 1'b0, "busy");
         wait_offer(1'b0);
         apb(1'b0, 16'h4080, 32'h0000_0000);
         chk(rd, {26'h000_0000, tgt, op[2:0]}, "pending");
         chk(media_ready, 1'b1, "ready");
      end
      $display("issue test done");
   endtask

   task automatic t_refuse();
      apb(1'b1, 16'h4080, 32'h0000_0088);
      repeat (4) begin
         @(posedge mclk);
         chk({valid_one, valid_two}, 2'h0, "no strobe");
      end
      apb(1'b0, 16'h4080, 32'h0000_0000);
      chk(rd, 32'h0000_0008, "dropped");
      apb(1'b0, 16'h40c0, 32'h0000_0000);
      chk(rd & 32'h0000_0020, 32'h0000_0020, "bad target");
      apb(1'b1, 16'h40c0, 32'h0000_0020);
      apb(1'b0, 16'h4000, 32'h0000_0000);
      chk({rerr, rd}, {1'h1, 32'h0000_0000}, "unmapped");
      $display("refusal test done");
   endtask

   task automatic t_auto();
      seq_active <= 1'b1;
      apb(1'b1, 16'h4084, 32'h0000_0000);
      apb(1'b0, 16'h4084, 32'h0000_0000);
      chk(rd, 32'h0000_003d, "auto write");
      apb(1'b0, 16'h40c0, 32'h0000_0000);
      chk(rd & 32'h0000_0031, 32'h0000_0011, "status");
      seq_fields <= {3'h4, 3'h2, 3'h4, 1'h0, 3'h1, 32'hcafe_0200, 41'h123_4567_8a00};
      seq_load <= 1'b1;
      @(posedge mclk);
      seq_load <= 1'b0;
      wait_offer(1'b1);
      chk(port_fields, seq_fields, "seq load");
      chk({valid_one, valid_two}, 2'h1, "auto strobe");
      wait_offer(1'b0);
      apb(1'b0, 16'h4080, 32'h0000_0000);
      chk(rd, 32'h0000_0022, "auto done");
      seq_active <= 1'b0;
      apb(1'b1, 16'h4082, 32'h0000_0081);
      @(posedge mclk);
      chk({rerr, port_fields.command}, {1'h1, 3'h2}, "unaligned");
      $display("auto test done");
   endtask

   initial begin
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      t_fields();
      t_issue();
      t_refuse();
      t_auto();
      finish_test();
   end
endmodule // media_command_port_regs_tb_top
